// ==== hdl/link_regs_pkg.sv ====
// Constants for the serial link identifier, frame character and status registers
//
// Behaviour
// - The programmed 8-bit identifier is sent in the second multiframe of lane alignment.
// - Selector 0 picks K28.7, 1 picks K28.1, 2 picks K28.5 and 3 is reserved.
// - The chosen end-of-frame comma is inserted only in 8B/10B modes, opportunistically.
// - Status bit 6 reads one while the serial link is up.
// - Status bit 5 reads 0 while SYNC~ is asserted and 1 while it is de-asserted.
// - Status bit 4 is set when SYSREF realigns a clock phase and cleared by writing one.
// - Status bit 3 is set by the first SYSREF after encoder enable and cleared by writing one.
// - Status bit 2 reads high while the serializer PLL is locked.
// - Status bit 0 reads high while the converter PLL is locked.
package link_regs_pkg;

   // ****************************************************************
   // Register indices; byte address is four times the index
   // ****************************************************************
   localparam logic [9:0] IDX_CTRL = 10'h200;
   localparam logic [9:0] IDX_IDENT = 10'h206;
   localparam logic [9:0] IDX_EOF_SEL = 10'h207;
   localparam logic [9:0] IDX_STATUS = 10'h208;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_IDENT = 8'h00;
   localparam logic [7:0] RST_EOF_SEL = 8'h00;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CTRL_ENC_EN = 0;
   localparam int CTRL_MODE_8B10B = 1;
   localparam int ST_LINK_UP = 6;
   localparam int ST_SYNC = 5;
   localparam int ST_REALIGNED = 4;
   localparam int ST_MULTIFRAME_PHASE_ESTABLISHED = 3;
   localparam int ST_SPLL = 2;
   localparam int ST_CPLL = 0;

   // ****************************************************************
   // Frame character codes, selector values and the second lane alignment multiframe index
   // ****************************************************************
   localparam logic [1:0] FSEL_K287 = 2'h0;
   localparam logic [1:0] FSEL_K281 = 2'h1;
   localparam logic [1:0] FSEL_K285 = 2'h2;
   localparam logic [7:0] K28_7 = 8'hFC;
   localparam logic [7:0] K28_1 = 8'h3C;
   localparam logic [7:0] K28_5 = 8'hBC;
   localparam logic [1:0] ILA_MF_SECOND = 2'h1;

   // ****************************************************************
   // Bus responses
   // ****************************************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : link_regs_pkg

// ==== hdl/serial_link_ident_status_regs.sv ====
// Identifier, frame character and status registers of the serial transmit link
//
// Our own choice: the AXI4-Lite register port.
module serial_link_ident_status_regs (
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Link side
   input wire logic sync_n_pin,
   input wire logic link_up,
   input wire logic sysref_realign,
   input wire logic sysref_event,
   input wire logic [1:0] ila_mf_index,
   input wire logic serializer_pll_lock,
   input wire logic converter_pll_lock,
   output logic link_encoder_enable,
   output logic mode_8b10b,
   output logic [7:0] ila_ident_q,
   output logic [7:0] eof_char_q,
   output logic eof_insert_q
);

   // ****************************************************************
   // Bus handshake state
   // ****************************************************************
   logic aw_have_q;
   logic [9:0] aw_idx_q;
   logic w_have_q;
   logic [7:0] wdata_q;
   logic wstrb0_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   // ****************************************************************
   // Registers and status
   // ****************************************************************
   logic [7:0] ctrl_q;
   logic [7:0] link_device_identifier_q;
   logic [7:0] frame_end_char_select_q;
   logic realigned_q;
   logic multiframe_phase_established_q;
   logic armed_q;
   logic enc_en_prev_q;
   logic link_up_q;
   logic sync_s1_q, sync_s2_q;
   logic spll_s1_q, spll_s2_q;
   logic cpll_s1_q, cpll_s2_q;

   // Handshake outputs
   assign s_axi_awready = !aw_have_q;
   assign s_axi_wready = !w_have_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // Write decode
   wire wr_go = aw_have_q && w_have_q && !bvalid_q;
   wire wr_en = wr_go && wstrb0_q;
   wire wr_ctrl = wr_en && (aw_idx_q == link_regs_pkg::IDX_CTRL);
   wire wr_ident = wr_en && (aw_idx_q == link_regs_pkg::IDX_IDENT);
   wire wr_eof_sel = wr_en && (aw_idx_q == link_regs_pkg::IDX_EOF_SEL);
   wire wr_status = wr_en && (aw_idx_q == link_regs_pkg::IDX_STATUS);
   wire wr_hit = (aw_idx_q == link_regs_pkg::IDX_CTRL) || (aw_idx_q == link_regs_pkg::IDX_IDENT)
      || (aw_idx_q == link_regs_pkg::IDX_EOF_SEL) || (aw_idx_q == link_regs_pkg::IDX_STATUS);

   // Read decode
   wire [9:0] ar_idx = s_axi_araddr[11:2];
   wire rd_go = s_axi_arvalid && !rvalid_q;
   wire [7:0] status_w;
   assign status_w = {1'b0, link_up_q, sync_s2_q, realigned_q, multiframe_phase_established_q, spll_s2_q,
      1'b0, cpll_s2_q};
   wire rd_hit = (ar_idx == link_regs_pkg::IDX_CTRL) || (ar_idx == link_regs_pkg::IDX_IDENT)
      || (ar_idx == link_regs_pkg::IDX_EOF_SEL) || (ar_idx == link_regs_pkg::IDX_STATUS);
   wire [7:0] rd_byte = (ar_idx == link_regs_pkg::IDX_CTRL) ? ctrl_q :
      (ar_idx == link_regs_pkg::IDX_IDENT) ? link_device_identifier_q :
      (ar_idx == link_regs_pkg::IDX_EOF_SEL) ? frame_end_char_select_q :
      (ar_idx == link_regs_pkg::IDX_STATUS) ? status_w : 8'h00;

   // Control fields steering the link
   assign link_encoder_enable = ctrl_q[link_regs_pkg::CTRL_ENC_EN];
   assign mode_8b10b = ctrl_q[link_regs_pkg::CTRL_MODE_8B10B];
   wire enc_rise = link_encoder_enable && !enc_en_prev_q;

   // Frame character lookup
   wire [1:0] fsel = frame_end_char_select_q[1:0];
   wire [7:0] eof_char_d = (fsel == link_regs_pkg::FSEL_K287) ? link_regs_pkg::K28_7 :
      (fsel == link_regs_pkg::FSEL_K281) ? link_regs_pkg::K28_1 :
      (fsel == link_regs_pkg::FSEL_K285) ? link_regs_pkg::K28_5 : link_regs_pkg::K28_7;
   wire fsel_legal = (fsel != 2'h3);

   // ****************************************************************
   // Write channel
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         aw_idx_q <= 10'h000;
      end else if (s_axi_awvalid && !aw_have_q) begin
         aw_have_q <= 1'b1;
         aw_idx_q <= s_axi_awaddr[11:2];
      end else if (wr_go) begin
         aw_have_q <= 1'b0;
      end
   end

   // Write data capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_q <= 1'b0;
         wdata_q <= 8'h00;
         wstrb0_q <= 1'b0;
      end else if (s_axi_wvalid && !w_have_q) begin
         w_have_q <= 1'b1;
         wdata_q <= s_axi_wdata[7:0];
         wstrb0_q <= s_axi_wstrb[0];
      end else if (wr_go) begin
         w_have_q <= 1'b0;
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= link_regs_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? link_regs_pkg::RESP_OKAY : link_regs_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ****************************************************************
   // Read channel
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= link_regs_pkg::RESP_OKAY;
      end else if (rd_go) begin
         rvalid_q <= 1'b1;
         rdata_q <= {24'h00_0000, rd_byte};
         rresp_q <= rd_hit ? link_regs_pkg::RESP_OKAY : link_regs_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= link_regs_pkg::RST_CTRL;
         link_device_identifier_q <= link_regs_pkg::RST_IDENT;
         frame_end_char_select_q <= link_regs_pkg::RST_EOF_SEL;
      end else begin
         if (wr_ctrl) ctrl_q <= {6'h00, wdata_q[1:0]};
         if (wr_ident) link_device_identifier_q <= wdata_q;
         if (wr_eof_sel) frame_end_char_select_q <= wdata_q; // Full byte kept
      end
   end

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_s1_q <= 1'b0;
         sync_s2_q <= 1'b0;
         spll_s1_q <= 1'b0;
         spll_s2_q <= 1'b0;
         cpll_s1_q <= 1'b0;
         cpll_s2_q <= 1'b0;
         link_up_q <= 1'b0;
      end else begin
         sync_s1_q <= sync_n_pin;
         sync_s2_q <= sync_s1_q; // Level of SYNC~
         spll_s1_q <= serializer_pll_lock;
         spll_s2_q <= spll_s1_q; // Serializer lock
         cpll_s1_q <= converter_pll_lock;
         cpll_s2_q <= cpll_s1_q; // Converter lock
         link_up_q <= link_up; // Link up
      end
   end

   // ****************************************************************
   // Sticky alignment flags; set wins over write-one clear
   // ****************************************************************
   wire clr_realign = wr_status && wdata_q[link_regs_pkg::ST_REALIGNED];
   wire clr_multiframe_phase_established = wr_status && wdata_q[link_regs_pkg::ST_MULTIFRAME_PHASE_ESTABLISHED];
   // A SYSREF in the very first enabled cycle already counts as the first one
   wire multiframe_phase_established_set = sysref_event && link_encoder_enable && (armed_q || enc_rise);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         realigned_q <= 1'b0;
         multiframe_phase_established_q <= 1'b0;
         armed_q <= 1'b0;
         enc_en_prev_q <= 1'b0;
      end else begin
         enc_en_prev_q <= link_encoder_enable;
         if (sysref_realign) realigned_q <= 1'b1;
         else if (clr_realign) realigned_q <= 1'b0;
         if (multiframe_phase_established_set) multiframe_phase_established_q <= 1'b1;
         else if (clr_multiframe_phase_established) multiframe_phase_established_q <= 1'b0;
         if (multiframe_phase_established_set || !link_encoder_enable) armed_q <= 1'b0;
         else if (enc_rise) armed_q <= 1'b1; // Armed until the first SYSREF
      end
   end

   // ****************************************************************
   // Link outputs; settings assumed static while encoder enabled
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ila_ident_q <= 8'h00;
         eof_char_q <= link_regs_pkg::K28_7;
         eof_insert_q <= 1'b0;
      end else begin
         if (link_encoder_enable && ila_mf_index == link_regs_pkg::ILA_MF_SECOND)
            ila_ident_q <= link_device_identifier_q;
         eof_char_q <= eof_char_d;
         eof_insert_q <= mode_8b10b && fsel_legal;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   // Encoder switched on: off in one cycle, on in the next
   sequence enc_enable_s;
      !link_encoder_enable ##1 link_encoder_enable;
   endsequence
   // Quiet enabling cycle, then the first SYSREF one cycle later
   sequence first_sysref_s;
      (link_encoder_enable && !sysref_event) ##1 (link_encoder_enable && sysref_event);
   endsequence

   // Identifier and frame character
   ident_in_ila_a: assert property (@(posedge aclk) disable iff (!aresetn)
      link_encoder_enable && ila_mf_index == link_regs_pkg::ILA_MF_SECOND
      |=> ila_ident_q == $past(link_device_identifier_q))
      else $error("identifier not placed in second multiframe");
   eof_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
      fsel == link_regs_pkg::FSEL_K285 |=> eof_char_q == link_regs_pkg::K28_5)
      else $error("wrong end-of-frame comma");
   eof_mode_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
      eof_insert_q |-> $past(mode_8b10b) && $past(fsel) != 2'h3)
      else $error("comma insertion outside 8B/10B mode");

   // Live status bits
   link_up_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
      link_up |=> status_w[6])
      else $error("link up not reported");
   link_down_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !link_up |=> !status_w[6])
      else $error("link up reported while down");
   sync_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ##2 status_w[5] == $past(sync_n_pin, 2))
      else $error("sync status does not follow pin");

   // Sticky alignment flags and PLL lock levels
   realign_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sysref_realign |=> status_w[4])
      else $error("realign event lost");
   multiframe_phase_established_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
      enc_enable_s ##0 first_sysref_s |=> status_w[3])
      else $error("multiframe_phase_established not set by first sysref");
   multiframe_phase_established_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      clr_multiframe_phase_established && !multiframe_phase_established_set |=> !status_w[3])
      else $error("write one did not clear multiframe_phase_established");
   sticky_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_status && !wdata_q[4] && realigned_q |=> realigned_q)
      else $error("write of zero cleared sticky bit");
   sticky_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      clr_realign && !sysref_realign |=> !realigned_q)
      else $error("write one did not clear");
   pll_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ##2 status_w[2] == $past(serializer_pll_lock, 2)
      && status_w[0] == $past(converter_pll_lock, 2))
      else $error("pll lock status mismatch");

endmodule : serial_link_ident_status_regs

// ==== testbench/link_far_end.sv ====
// Behavioural model of the receiver at the far end of the serial link
module link_far_end (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic enc_en,
   input wire logic fault,
   output logic sync_n_pin,
   output logic link_up,
   output logic [1:0] ila_mf_index
);
   timeunit 1ns;
   timeprecision 1ns;

   // ****************************************************************
   // Link bring-up sequence
   // ****************************************************************
   logic [3:0] step_q;

   // Restart when the encoder stops or the bench injects a lane fault
   always_ff @(posedge aclk) begin
      if (!aresetn || !enc_en || fault) begin
         step_q <= 4'h0;
      end else if (step_q != 4'hF) begin
         step_q <= step_q + 4'h1;
      end
   end

   // SYNC~ held low during code group sync, then four alignment multiframes
   assign sync_n_pin = (step_q >= 4'h4);
   assign ila_mf_index = (step_q < 4'h4) ? 2'h0 : (step_q > 4'h7) ? 2'h3 : step_q[1:0];
   assign link_up = (step_q > 4'h7);
endmodule : link_far_end

// ==== testbench/serial_link_ident_status_regs_tb.sv ====
// Self-checking bench for the link identifier, frame character and status registers
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] %s expected %0h seen %0h", n, e, g); end end
module serial_link_ident_status_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;

   // ****************************************************************
   // Signals and addresses
   // ****************************************************************
   logic aclk, aresetn, aw_v, aw_r, w_v, w_r, b_v, b_rd, ar_v, ar_r, r_v, r_rd;
   logic [11:0] aw_a, ar_a;
   logic [31:0] w_d, r_d, d;
   logic [3:0] w_s;
   logic [1:0] b_r, r_r, mf, rsp;
   logic sync_n, lnk, realign, sev, spll, cpll, enc, m8, ins, fault;
   logic [7:0] ident, echar, id_val;
   int num_errors, compares, i;
   localparam logic [11:0] A_CTRL = {link_regs_pkg::IDX_CTRL, 2'h0};
   localparam logic [11:0] A_IDENT = {link_regs_pkg::IDX_IDENT, 2'h0};
   localparam logic [11:0] A_FC = {link_regs_pkg::IDX_EOF_SEL, 2'h0};
   localparam logic [11:0] A_ST = {link_regs_pkg::IDX_STATUS, 2'h0};

   serial_link_ident_status_regs serial_link_ident_status_regs_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
      .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_r),
      .s_axi_bvalid(b_v), .s_axi_bready(b_rd), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
      .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_r), .s_axi_rvalid(r_v),
      .s_axi_rready(r_rd), .sync_n_pin(sync_n), .link_up(lnk), .sysref_realign(realign),
      .sysref_event(sev), .ila_mf_index(mf), .serializer_pll_lock(spll),
      .converter_pll_lock(cpll), .link_encoder_enable(enc), .mode_8b10b(m8),
      .ila_ident_q(ident), .eof_char_q(echar), .eof_insert_q(ins));

   link_far_end link_far_end_i (.aclk(aclk), .aresetn(aresetn), .enc_en(enc), .fault(fault),
      .sync_n_pin(sync_n), .link_up(lnk), .ila_mf_index(mf));

   // Free-running 10 MHz clock
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   // ****************************************************************
   // Bus tasks and expectations
   // ****************************************************************
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test

   task automatic wr32(input logic [11:0] a, input logic [31:0] v, output logic [1:0] r);
      int n;
      aw_a <= a;
      w_d <= v;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (aw_v && aw_r) aw_v <= 1'b0;
         if (w_v && w_r) w_v <= 1'b0;
         if (b_v) break;
      end
      r = b_r;
      if (n == 40) begin
         num_errors++;
         finish_test();
      end
   endtask : wr32

   task automatic rd32(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
      int n;
      ar_a <= a;
      ar_v <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (ar_v && ar_r) ar_v <= 1'b0;
         if (r_v) break;
      end
      v = r_d;
      r = r_r;
      if (n == 40) begin
         num_errors++;
         finish_test();
      end
   endtask : rd32

   function automatic logic [7:0] char_exp(input logic [1:0] s);
      case (s)
         2'h1: return link_regs_pkg::K28_1;
         2'h2: return link_regs_pkg::K28_5;
         default: return link_regs_pkg::K28_7;
      endcase
   endfunction : char_exp

   // Reads status and compares with live inputs plus the expected sticky flags
   task automatic chk_status(input logic [7:0] sticky);
      rd32(A_ST, d, rsp);
      `CHK("status", {24'h0, 1'b0, lnk, sync_n, sticky[4:3], spll, 1'b0, cpll}, d)
   endtask : chk_status

   task automatic pulse(input logic re);
      if (re) realign <= 1'b1;
      else sev <= 1'b1;
      @(posedge aclk);
      realign <= 1'b0;
      sev <= 1'b0;
      @(posedge aclk);
   endtask : pulse

   // Waits for the far end to report the link up, then lets the status settle
   task automatic wait_link();
      int n;
      for (n = 0; n < 40 && !lnk; n++) @(posedge aclk);
      if (n == 40) begin
         num_errors++;
         finish_test();
      end
      repeat (3) @(posedge aclk);
   endtask : wait_link

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      aresetn = 1'b0;
      {aw_v, w_v, ar_v, realign, sev, spll, cpll, fault} = 8'h00;
      {b_rd, r_rd, w_s, aw_a, ar_a, w_d} = {2'h3, 4'hF, 56'h0};
      num_errors = 0;
      compares = 0;
      void'($urandom(31484));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd32(A_IDENT, d, rsp);
      `CHK("ident reset", 32'h0, d)
      rd32(A_FC, d, rsp);
      `CHK("eof sel reset", 32'h0, d)
      chk_status(8'h00);
      rd32(12'h824, d, rsp);
      `CHK("unmapped rresp", link_regs_pkg::RESP_SLVERR, rsp)
      wr32(12'h824, 32'hFF, rsp);
      `CHK("unmapped bresp", link_regs_pkg::RESP_SLVERR, rsp)
      $display("test reset done");
      // Every selector with and without 8B/10B, encoder kept off while changing it
      for (i = 0; i < 8; i++) begin
         wr32(A_CTRL, {30'h0, i[2], 1'b0}, rsp);
         wr32(A_FC, {30'h0, i[1:0]}, rsp);
         // The comma output is registered one cycle behind the selector
         @(posedge aclk);
         `CHK("eof char", char_exp(i[1:0]), echar)
         `CHK("eof insert", i[2] && (i[1:0] != 2'h3), ins)
         rd32(A_FC, d, rsp);
         `CHK("eof sel read", {30'h0, i[1:0]}, d)
      end
      wr32(A_FC, 32'h0, rsp);
      $display("test frame char done");
      id_val = 8'($urandom);
      wr32(A_IDENT, {24'h0, id_val}, rsp);
      rd32(A_IDENT, d, rsp);
      `CHK("ident read", {24'h0, id_val}, d)
      wr32(A_CTRL, 32'h3, rsp);
      wait_link();
      `CHK("ila ident", id_val, ident)
      $display("test identifier done");
      // Sticky flags: set, kept by zero write, cleared by one, first event only
      pulse(1'b0);
      chk_status(8'h08);
      wr32(A_ST, 32'h0, rsp);
      chk_status(8'h08);
      wr32(A_ST, 32'h08, rsp);
      chk_status(8'h00);
      pulse(1'b0);
      chk_status(8'h00);
      pulse(1'b1);
      chk_status(8'h10);
      wr32(A_ST, 32'hFF, rsp);
      chk_status(8'h00);
      // Re-enable and send SYSREF in the second cycle after the enable lands, after one quiet enabled cycle
      wr32(A_CTRL, 32'h2, rsp);
      wr32(A_CTRL, 32'h3, rsp);
      pulse(1'b0);
      wait_link();
      chk_status(8'h08);
      wr32(A_ST, 32'h08, rsp);
      chk_status(8'h00);
      $display("test sticky done");
      // Random lock levels and link drops from the far side
      for (i = 0; i < 8; i++) begin
         spll <= 1'($urandom);
         cpll <= 1'($urandom);
         fault <= 1'($urandom);
         repeat (20) @(posedge aclk);
         chk_status(8'h00);
      end
      $display("test live status done");
      finish_test();
   end
endmodule : serial_link_ident_status_regs_tb
